//--- src/thi_pkg.sv
// Package of constants and types for the touch host interface select block
package thi_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned THI_SENSE_CNT = 16;   // Number of sense inputs
  localparam int unsigned THI_SYNC_STAGES = 2;  // Synchroniser depth
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic THI_IRQ_RST = 1'h0;          // Interrupt idle level
  localparam logic THI_PIN_HIZ_OE_N = 1'h1;     // Output enable off (active low)
  localparam logic THI_PIN_DRIVE_OE_N = 1'h0;   // Output enable on (active low)
  localparam logic THI_SYNC_RST = 1'h1;         // Synchroniser reset level (idle high)
  // Host port modes
  typedef enum logic [0:0] {THI_MODE_I2C, THI_MODE_SPI} thi_mode_type;
endpackage

//--- src/thi_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module thi_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  import thi_pkg::*;
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (WIDTH < 1)
  begin : g_chk
    $error("WIDTH must be at least one");
  end
  logic [WIDTH-1:0] meta_q; // First stage, read only by second stage
  logic [WIDTH-1:0] sync_q; // Second stage
  // Two stages; reset forces idle-high so no false edge on release
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      meta_q <= {WIDTH{THI_SYNC_RST}};
      sync_q <= {WIDTH{THI_SYNC_RST}};
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

//--- src/thi_top.sv
// Host pin multiplexer and mode control of the capacitive touch converter
// What this block does
// - Start in I2C mode after every initialization
// - Chip select held high keeps I2C mode
// - Chip select falling edge switches to SPI
// - SPI mode latched until next initialization
// - SPI mode: chip select is active low
// - Shared clock pin feeds I2C or SPI
// - Data pin: I2C bidirectional, SPI input
// - Address pin: I2C select input, SPI output
// - Low external reset holds device in reset
// - Reset puts sense and reference pins Hi-Z
// - Interrupt output drives active high
`timescale 1ns/1ps
module thi_top
#(
  parameter int unsigned SENSE_CNT = thi_pkg::THI_SENSE_CNT
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // External pins
  input wire logic i_external_reset_n,
  input wire logic i_if_select_chip_select_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  output logic o_serial_data,
  output logic o_serial_data_oe_n,
  input wire logic i_addr_sel0_or_serial_out,
  output logic o_addr_sel0_or_serial_out,
  output logic o_addr_sel0_or_serial_out_oe_n,
  input wire logic i_addr_sel1,
  output logic o_host_irq_out,
  output logic [SENSE_CNT-1:0] o_sense_inputs_oe_n,
  output logic o_reference_cap_oe_n,
  output logic o_reference_cap_extra_input_oe_n,
  // Core side: analog sequencer and protocol engines
  input wire logic [SENSE_CNT-1:0] i_core_sense_oe_n,
  input wire logic i_core_ref_oe_n,
  input wire logic i_core_ref_extra_oe_n,
  input wire logic i_core_irq,
  input wire logic i_i2c_sda_out,
  input wire logic i_i2c_sda_oe_n,
  input wire logic i_spi_sdo,
  output logic o_mode_spi,
  output logic o_core_reset,
  output logic o_i2c_scl,
  output logic o_i2c_sda_in,
  output logic [1:0] o_i2c_addr_sel,
  output logic o_spi_sck,
  output logic o_spi_sdi,
  output logic o_spi_cs_n
);
  import thi_pkg::*;

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (SENSE_CNT < 1)
  begin : g_chk
    $error("SENSE_CNT must be at least one");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int unsigned NSYNC = 6; // Pins passed through the synchroniser
  logic [NSYNC-1:0] pins_raw; // Raw pin levels
  logic [NSYNC-1:0] pins_s; // Synchronised pin levels
  logic rst_n_s; // External reset, synchronised
  logic cs_n_s; // Chip select, synchronised
  logic sclk_s; // Serial clock, synchronised
  logic sdata_s; // Serial data, synchronised
  logic asel0_s; // Address select 0, synchronised
  logic asel1_s; // Address select 1, synchronised

  assign pins_raw = {i_external_reset_n, i_if_select_chip_select_n, i_serial_clk,
                     i_serial_data, i_addr_sel0_or_serial_out, i_addr_sel1};

  // Every pin passes two flops before logic reads it
  thi_sync #(.WIDTH(NSYNC)) u_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  assign {rst_n_s, cs_n_s, sclk_s, sdata_s, asel0_s, asel1_s} = pins_s;

  // ----------------------------------------
  // Initialization
  // ----------------------------------------
  logic in_reset; // Power-on or external reset active
  logic init_q; // High in first cycle after reset released

  // Low external reset keeps device in reset; power-on reset does too
  assign in_reset = i_srst | ~rst_n_s;

  // Marks release of reset as an initialization
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      init_q <= 1'h1;
    end
    else
    begin
      init_q <= ~rst_n_s;
    end
  end

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  thi_mode_type mode_q; // Current host port mode
  logic cs_n_prev_q; // Chip select, previous sample
  logic cs_fall; // Chip select high-to-low edge

  // Previous chip select; tracks the synchronised pin during reset so a select
  // already held low at external reset release gives no edge
  always_ff @(posedge i_ref_clk)
  begin
    if (in_reset)
    begin
      cs_n_prev_q <= cs_n_s;
    end
    else
    begin
      cs_n_prev_q <= cs_n_s;
    end
  end

  assign cs_fall = cs_n_prev_q & ~cs_n_s;

  // Mode latch: I2C after initialization, SPI once chip select falls
  always_ff @(posedge i_ref_clk)
  begin
    if (in_reset)
    begin
      mode_q <= THI_MODE_I2C;
    end
    else
    begin
      case (mode_q)
        THI_MODE_I2C:
        begin
          if (cs_fall)
          begin
            mode_q <= THI_MODE_SPI;
          end
          else
          begin
            mode_q <= THI_MODE_I2C;
          end
        end
        THI_MODE_SPI:
        begin
          mode_q <= THI_MODE_SPI;
        end
        default:
        begin
          mode_q <= THI_MODE_I2C;
        end
      endcase
    end
  end

  logic is_spi; // Host port in SPI mode
  assign is_spi = (mode_q == THI_MODE_SPI);
  assign o_mode_spi = is_spi;
  assign o_core_reset = in_reset | init_q;

  // ----------------------------------------
  // Shared pin routing
  // ----------------------------------------
  // Core-facing pin copies, registered; idle values outside own mode
  always_ff @(posedge i_ref_clk)
  begin
    if (in_reset)
    begin
      o_i2c_scl <= THI_SYNC_RST;
      o_i2c_sda_in <= THI_SYNC_RST;
      o_i2c_addr_sel <= 2'h0;
      o_spi_sck <= THI_SYNC_RST;
      o_spi_sdi <= 1'h0;
      o_spi_cs_n <= THI_SYNC_RST;
    end
    else
    begin
      o_i2c_scl <= is_spi ? THI_SYNC_RST : sclk_s;
      o_i2c_sda_in <= is_spi ? THI_SYNC_RST : sdata_s;
      o_i2c_addr_sel <= is_spi ? 2'h0 : {asel1_s, asel0_s};
      o_spi_sck <= is_spi ? sclk_s : THI_SYNC_RST;
      o_spi_sdi <= is_spi ? sdata_s : 1'h0;
      o_spi_cs_n <= is_spi ? cs_n_s : THI_SYNC_RST;
    end
  end

  // Pin drivers: data out from flops, enables follow the mode
  always_ff @(posedge i_ref_clk)
  begin
    if (in_reset)
    begin
      o_serial_data <= 1'h0;
      o_serial_data_oe_n <= THI_PIN_HIZ_OE_N;
      o_addr_sel0_or_serial_out <= 1'h0;
      o_addr_sel0_or_serial_out_oe_n <= THI_PIN_HIZ_OE_N;
    end
    else if (is_spi)
    begin
      // SPI: data pin is input only, address pin drives serial out while chip select is low
      o_serial_data <= 1'h0;
      o_serial_data_oe_n <= THI_PIN_HIZ_OE_N;
      o_addr_sel0_or_serial_out <= i_spi_sdo;
      o_addr_sel0_or_serial_out_oe_n <= cs_n_s ? THI_PIN_HIZ_OE_N : THI_PIN_DRIVE_OE_N;
    end
    else
    begin
      // I2C: data pin is bidirectional, data and enable from the I2C engine, address pin is input
      o_serial_data <= i_i2c_sda_out;
      o_serial_data_oe_n <= i_i2c_sda_oe_n;
      o_addr_sel0_or_serial_out <= 1'h0;
      o_addr_sel0_or_serial_out_oe_n <= THI_PIN_HIZ_OE_N;
    end
  end

  // ----------------------------------------
  // Analog pin release and interrupt
  // ----------------------------------------
  // Sense and reference pins Hi-Z in reset; interrupt active high
  always_ff @(posedge i_ref_clk)
  begin
    if (in_reset)
    begin
      o_sense_inputs_oe_n <= {SENSE_CNT{THI_PIN_HIZ_OE_N}};
      o_reference_cap_oe_n <= THI_PIN_HIZ_OE_N;
      o_reference_cap_extra_input_oe_n <= THI_PIN_HIZ_OE_N;
      o_host_irq_out <= THI_IRQ_RST;
    end
    else
    begin
      o_sense_inputs_oe_n <= i_core_sense_oe_n;
      o_reference_cap_oe_n <= i_core_ref_oe_n;
      o_reference_cap_extra_input_oe_n <= i_core_ref_extra_oe_n;
      o_host_irq_out <= i_core_irq;
    end
  end
endmodule

//--- test/thi_host_model.sv
// Host model driving mode select, framed serial clock, data and address strap 0
`timescale 1ns/1ps
module thi_host_model
(
  input wire logic i_frame,
  input wire logic i_cs_n,
  input wire logic i_data,
  input wire logic i_strap0,
  input wire logic i_dev_sda,
  input wire logic i_dev_sda_oe_n,
  input wire logic i_dev_sout,
  input wire logic i_dev_sout_oe_n,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sda_wire,
  output logic o_strap0_wire
);
  // Host holds select high for I2C, pulls it low for SPI
  assign o_cs_n = i_cs_n;
  // Serial clock runs only inside frames, idles high
  initial o_sclk = 1'b1;
  always #32 o_sclk = i_frame ? ~o_sclk : 1'b1;
  // Data line with pull-up: either party may pull low
  assign o_sda_wire = ((!i_dev_sda_oe_n && !i_dev_sda) || !i_data) ? 1'b0 : 1'b1;
  // Address pin: strap level unless the device drives it
  assign o_strap0_wire = !i_dev_sout_oe_n ? i_dev_sout : i_strap0;
endmodule

//--- test/thi_chk.sv
// Checker of mode select, pin routing and reset behaviour at the top ports
`timescale 1ns/1ps
module thi_chk
#(
  parameter int unsigned SENSE_CNT = 16
)
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_external_reset_n,
  input wire logic i_if_select_chip_select_n,
  input wire logic i_serial_clk,
  input wire logic i_core_irq,
  input wire logic o_mode_spi,
  input wire logic o_core_reset,
  input wire logic o_host_irq_out,
  input wire logic o_spi_sck,
  input wire logic o_spi_cs_n,
  input wire logic o_serial_data_oe_n,
  input wire logic o_addr_sel0_or_serial_out_oe_n,
  input wire logic [SENSE_CNT-1:0] o_sense_inputs_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_init_i2c_mode: assert property ($fell(o_core_reset) |-> !o_mode_spi)
    else $error("mode not I2C");
  a_cs_high_keeps: assert property ((i_if_select_chip_select_n [*4]) ##0 !o_mode_spi |=> !o_mode_spi)
    else $error("mode left I2C");
  a_cs_fall_spi: assert property (!i_if_select_chip_select_n && $past(i_if_select_chip_select_n)
    && $past(i_if_select_chip_select_n, 2) && !o_core_reset && i_external_reset_n
    |-> ##3 (o_mode_spi || o_core_reset)) else $error("no SPI switch");
  a_spi_sticky: assert property ((i_external_reset_n [*4]) ##0 o_mode_spi |=> o_mode_spi)
    else $error("SPI mode lost");
  a_cs_drives_out: assert property (!o_core_reset |-> o_spi_cs_n == o_addr_sel0_or_serial_out_oe_n)
    else $error("serial out drive wrong");
  a_sck_route: assert property (o_mode_spi && $past(o_mode_spi, 4) && !o_core_reset
    |-> o_spi_sck == $past(i_serial_clk, 3)) else $error("SPI clock route wrong");
  a_sda_spi_in: assert property (o_mode_spi && $past(o_mode_spi) |-> o_serial_data_oe_n)
    else $error("data pin driven in SPI");
  a_ext_reset: assert property ((!i_external_reset_n) [*5] |-> o_core_reset)
    else $error("no reset");
  // Pin enables are registered, so they lag the reset indicator by one cycle
  a_reset_hiz: assert property (o_core_reset && $past(o_core_reset) |-> &o_sense_inputs_oe_n)
    else $error("sense not Hi-Z");
  a_irq_follow: assert property (!o_core_reset |=> o_host_irq_out == $past(i_core_irq))
    else $error("irq wrong");
  c_spi_switch: cover property ($rose(o_mode_spi));
  c_irq_raise: cover property ($rose(o_host_irq_out));
  c_reinit_spi: cover property ($rose(o_core_reset) && o_mode_spi);
endmodule

//--- test/touch_host_interface_select_bench.sv
// Self-checking bench of the host interface select block
`timescale 1ns/1ps
module touch_host_interface_select_bench;
  import thi_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1, ext_n = 1'b1, cs_n = 1'b1, frame = 1'b0, sda = 1'b1, strap0 = 1'b1, strap1 = 1'b0;
  logic irq = 1'b0, sda_out = 1'b1, sda_oe_n = 1'b1, sdo = 1'b0;
  logic [15:0] core_oe_n = 16'h0000;
  logic cs_w, sclk_w, sda_w, strap0_w, sd_o, sd_oe_n, sout, sout_oe_n, irq_o, ref_oe_n, refx_oe_n;
  logic mode_spi, core_rst, scl, sda_in, sck, sdi, spi_cs_n;
  logic [1:0] addr_sel;
  logic [15:0] sense_oe_n;
  int errors = 0, cmp_count = 0, cycles = 0;
  // ----------------------------------------
  // Clock, timeout, verdict
  // ----------------------------------------
  always #2.5 clk = ~clk;
  task automatic report_and_stop;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Scenario inputs change 1 ns after a rising edge; the framed serial clock toggles every 32 ns on its own
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_i2c;
    chk("mode", mode_spi, 0);
    strap0 = 1'b0;
    strap1 = 1'b1;
    frame = 1'b1;
    sda_oe_n = 1'b0;
    sda_out = 1'b0;
    step(40);
    chk("mode", mode_spi, 0);
    chk("addr", addr_sel, 2'h2);
    chk("sda_oe", sd_oe_n, 0);
    chk("sda_in", sda_in, 0);
    chk("spi_cs", spi_cs_n, 1);
    // Catch a fresh low phase of the framed clock; it must reach the I2C copy
    wait (sclk_w == 1'b1);
    wait (sclk_w == 1'b0);
    step(4);
    chk("scl", scl, 0);
    frame = 1'b0;
    sda_oe_n = 1'b1;
    step(20);
    chk("scl", scl, 1);
    chk("sck", sck, 1);
  endtask
  task automatic t_spi;
    cs_n = 1'b0;
    step(2);
    chk("mode", mode_spi, 0);
    step(1);
    chk("mode", mode_spi, 1);
    sdo = 1'b1;
    frame = 1'b1;
    step(6);
    chk("sout_oe", sout_oe_n, 0);
    chk("sout", strap0_w, 1);
    chk("sda_oe", sd_oe_n, 1);
    chk("sdi", sdi, 1);
    chk("spi_cs", spi_cs_n, 0);
    chk("scl", scl, 1);
    cs_n = 1'b1;
    frame = 1'b0;
    step(10);
    chk("mode", mode_spi, 1);
    chk("sout_oe", sout_oe_n, 1);
  endtask
  task automatic t_reset;
    irq = 1'b1;
    step(2);
    chk("irq", irq_o, 1);
    ext_n = 1'b0;
    step(6);
    chk("core_rst", core_rst, 1);
    chk("sense_oe", sense_oe_n, 16'hFFFF);
    chk("ref_oe", {refx_oe_n, ref_oe_n}, 2'h3);
    chk("irq", irq_o, 0);
    ext_n = 1'b1;
    step(6);
    chk("mode", mode_spi, 0);
    chk("sense_oe", sense_oe_n, 0);
    cs_n = 1'b0;
    step(5);
    chk("mode", mode_spi, 1);
    srst = 1'b1;
    cs_n = 1'b1;
    step(3);
    srst = 1'b0;
    step(4);
    chk("mode", mode_spi, 0);
    chk("core_rst", core_rst, 0);
  endtask
  initial
  begin
    step(6);
    srst = 1'b0;
    step(3);
    t_i2c();
    t_spi();
    t_reset();
    report_and_stop();
  end
  thi_host_model u_host (.i_frame(frame), .i_cs_n(cs_n), .i_data(sda), .i_strap0(strap0), .i_dev_sda(sd_o),
    .i_dev_sda_oe_n(sd_oe_n), .i_dev_sout(sout), .i_dev_sout_oe_n(sout_oe_n), .o_cs_n(cs_w),
    .o_sclk(sclk_w), .o_sda_wire(sda_w), .o_strap0_wire(strap0_w));
  thi_top DUT (.i_ref_clk(clk), .i_srst(srst), .i_external_reset_n(ext_n), .i_if_select_chip_select_n(cs_w),
    .i_serial_clk(sclk_w), .i_serial_data(sda_w), .o_serial_data(sd_o), .o_serial_data_oe_n(sd_oe_n),
    .i_addr_sel0_or_serial_out(strap0_w), .o_addr_sel0_or_serial_out(sout),
    .o_addr_sel0_or_serial_out_oe_n(sout_oe_n), .i_addr_sel1(strap1), .o_host_irq_out(irq_o),
    .o_sense_inputs_oe_n(sense_oe_n), .o_reference_cap_oe_n(ref_oe_n), .o_reference_cap_extra_input_oe_n(refx_oe_n),
    .i_core_sense_oe_n(core_oe_n), .i_core_ref_oe_n(1'b0), .i_core_ref_extra_oe_n(1'b0), .i_core_irq(irq),
    .i_i2c_sda_out(sda_out), .i_i2c_sda_oe_n(sda_oe_n), .i_spi_sdo(sdo), .o_mode_spi(mode_spi),
    .o_core_reset(core_rst), .o_i2c_scl(scl), .o_i2c_sda_in(sda_in), .o_i2c_addr_sel(addr_sel),
    .o_spi_sck(sck), .o_spi_sdi(sdi), .o_spi_cs_n(spi_cs_n));
endmodule
bind thi_top thi_chk #(.SENSE_CNT(SENSE_CNT)) u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_external_reset_n(i_external_reset_n), .i_if_select_chip_select_n(i_if_select_chip_select_n),
  .i_serial_clk(i_serial_clk), .i_core_irq(i_core_irq), .o_mode_spi(o_mode_spi), .o_core_reset(o_core_reset),
  .o_host_irq_out(o_host_irq_out), .o_spi_sck(o_spi_sck), .o_spi_cs_n(o_spi_cs_n),
  .o_serial_data_oe_n(o_serial_data_oe_n), .o_addr_sel0_or_serial_out_oe_n(o_addr_sel0_or_serial_out_oe_n),
  .o_sense_inputs_oe_n(o_sense_inputs_oe_n));
